// ==== shared/adcc_if.sv ====
// signals between the control core and its prescaler and formatter
interface adcc_if;
  logic       src_tick;
  logic [2:0] div_code;
  logic       conv_tick;
  logic [9:0] raw;
  logic [1:0] mode;
  logic [7:0] res_hi;
  logic [7:0] res_lo;
  modport pre (input src_tick, input div_code, output conv_tick);
  modport fmt (input raw, input mode, output res_hi, output res_lo);
  modport ctl (output src_tick, output div_code, input conv_tick,
               output raw, output mode, input res_hi, input res_lo);
endinterface

// ==== shared/adcc_pkg.sv ====
// constants and types shared by the converter control block
// Functional notes
// - flag sets per conversion, cleared by control writes or low result read
// - with interrupt enabled the flag reads zero and an interrupt is raised
// - interrupt drops on result 0 high or low byte read or status/control write
// - reset clears flag, interrupt enable and continuous bit
// - continuous bit repeats conversions, otherwise one conversion per start, or one per channel with scan on
// - channel codes 0 to 7 select port A pins 0 to 7
// - reserved channel codes give an undefined result
// - codes 29 and 30 pick internal references, 31 powers off
// - prescaler divides by 1, 2, 4, 8 or 16
// - clock select one is bus clock, zero oscillator, reset oscillator
// - justification codes truncated, right, left, left signed; reset right
// - registers decoded at indices 0x57 to 0x5E
// - status/control write starts a conversion of 16 to 17 converter clocks
// - high byte read freezes low byte until read, except truncated; control writes release it
// - result bits placed per justification, sign mode inverts bit nine
// - auto-scan counter restarts on status/control write, runs channels up to limit, or cycles through all four when continuous
package adcc_pkg;
  localparam int          ADDR_W        = 10;
  // register indices; byte address is four times the index
  localparam logic [7:0]  IDX_SCR       = 8'h57;
  localparam logic [7:0]  IDX_CLK       = 8'h58;
  localparam logic [7:0]  IDX_R0_HI     = 8'h59;
  localparam logic [7:0]  IDX_R0_LO     = 8'h5A;
  localparam logic [7:0]  IDX_R1        = 8'h5B;
  localparam logic [7:0]  IDX_R2        = 8'h5C;
  localparam logic [7:0]  IDX_R3        = 8'h5D;
  localparam logic [7:0]  IDX_SCAN      = 8'h5E;
  // status/control fields
  localparam int          SCR_DONE_B    = 7;
  localparam int          SCR_IEN_B     = 6;
  localparam int          SCR_CONT_B    = 5;
  // clock control fields
  localparam int          CLK_DIV_B     = 5;
  localparam int          CLK_SEL_B     = 4;
  localparam int          CLK_MODE_B    = 2;
  // scan control fields
  localparam int          SCAN_EN_B     = 2;
  localparam logic [4:0]  CHAN_RST      = 5'h1F;
  localparam logic [4:0]  CHAN_OFF      = 5'h1F;
  localparam logic [2:0]  DIV_RST       = 3'h0;
  localparam logic [1:0]  MODE_TRUNC    = 2'h0;
  localparam logic [1:0]  MODE_RIGHT    = 2'h1;
  localparam logic [1:0]  MODE_LEFT     = 2'h2;
  localparam logic [1:0]  MODE_SIGN     = 2'h3;
  localparam logic [3:0]  CONV_TICKS    = 4'hF;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SYNC = 2'h1,
    ST_CONV = 2'h3,
    ST_DONE = 2'h2
  } adcc_state_type;
endpackage

// ==== testbench/adcc_core_model.sv ====
// behavioural analog multiplexer and converter core facing the control block
module adcc_core_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic [4:0] i_mux_sel,
  input  wire logic       i_power_down,
  input  wire logic       i_conv_start,
  input  wire logic       i_busy,
  output logic      [9:0] o_data,
  output logic      [9:0] o_sample
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] step_q;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sample <= 10'h2A5;
      step_q   <= 10'h000;
    end else if (i_conv_start) begin
      // every conversion yields a new value so a stale result cannot pass
      o_sample <= 10'h2A5 + {i_mux_sel, 5'h00} + step_q;
      step_q   <= step_q + 10'h137;
    end
  end
  // outside a conversion or powered off the output is not held
  assign o_data = (i_busy && !i_power_down) ? o_sample : ~o_sample;
endmodule

// ==== testbench/testbench.sv ====
// self-checking bench for the converter control block
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH at %0t: got %0h expected %0h", $time, (g), (e)); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        pdown, start, strobe, busy, irq, osc;
  logic [9:0]  paddr, core, smp;
  logic [31:0] pwdata, prdata;
  logic [4:0]  mux;
  logic [2:0]  osc_cnt;
  int          fails, tests_run;

  adcc_top DUT (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_OSC_CLK(osc), .I_CORE_DATA(core),
    .O_MUX_SEL(mux), .O_POWER_DOWN(pdown), .O_CONV_START(start), .O_CONV_STROBE(strobe),
    .O_BUSY(busy), .O_IRQ(irq));
  adcc_core_model core_model (.i_clk(clk), .i_rst_n(rst_n), .i_mux_sel(mux),
    .i_power_down(pdown), .i_conv_start(start), .i_busy(busy), .o_data(core),
    .o_sample(smp));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // oscillator at an eighth of the bus clock, 1.25 MHz, above 1 MHz
  always @(posedge clk) osc_cnt <= osc_cnt + 3'h1;
  assign osc = osc_cnt[2];

  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd, output logic err);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd  = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wreg(input logic [7:0] idx, input logic [7:0] wd);
    logic [7:0] r;
    logic       e;
    bus(1'b1, idx, wd, r, e);
    @(posedge clk);
  endtask
  task automatic rreg(input logic [7:0] idx, output logic [7:0] rd);
    logic e;
    bus(1'b0, idx, 8'h00, rd, e);
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    repeat (3) @(posedge clk);
    while (busy !== 1'b0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
  endtask
  function automatic logic [15:0] fmt(input logic [1:0] m, input logic [9:0] v);
    case (m)
      2'h0:    fmt = {8'h00, v[9:2]};
      2'h1:    fmt = {6'h00, v};
      2'h2:    fmt = {v, 6'h00};
      default: fmt = {~v[9], v[8:0], 6'h00};
    endcase
  endfunction

  task automatic t_reset;
    logic [7:0] r;
    logic       e;
    rreg(adcc_pkg::IDX_SCR, r);    `CHK(r, 8'h1F)
    rreg(adcc_pkg::IDX_CLK, r);    `CHK(r, 8'h04)
    rreg(adcc_pkg::IDX_R0_LO, r);  `CHK(r, 8'h00)
    rreg(adcc_pkg::IDX_SCAN, r);   `CHK(r, 8'h00)
    bus(1'b0, 8'h60, 8'h00, r, e); `CHK(e, 1'b1)
    `CHK(pdown, 1'b1)
  endtask
  task automatic t_single;
    logic [7:0] r;
    // bus clock over 16 gives 625 kHz, inside the converter band
    wreg(adcc_pkg::IDX_CLK, 8'h94);
    wreg(adcc_pkg::IDX_SCR, 8'h03);
    `CHK(mux, 5'h03)
    wait_idle();
    rreg(adcc_pkg::IDX_SCR, r);   `CHK(r, 8'h83)
    repeat (40) @(posedge clk);
    `CHK(busy, 1'b0)
    rreg(adcc_pkg::IDX_R0_HI, r); `CHK(r, {6'h00, smp[9:8]})
    rreg(adcc_pkg::IDX_R0_LO, r); `CHK(r, smp[7:0])
    rreg(adcc_pkg::IDX_SCR, r);   `CHK(r, 8'h03)
    wreg(adcc_pkg::IDX_SCR, 8'h03);
    wait_idle();
    wreg(adcc_pkg::IDX_CLK, 8'h94);
    rreg(adcc_pkg::IDX_SCR, r);   `CHK(r, 8'h03)
  endtask
  task automatic t_modes;
    logic [7:0] h, l;
    for (int m = 0; m < 4; m++) begin
      wreg(adcc_pkg::IDX_CLK, 8'h90 | 8'(m << 2));
      wreg(adcc_pkg::IDX_SCR, 8'h05);
      wait_idle();
      rreg(adcc_pkg::IDX_R0_HI, h);
      rreg(adcc_pkg::IDX_R0_LO, l);
      `CHK({h, l}, fmt(2'(m), smp))
    end
  endtask
  task automatic t_irq;
    logic [7:0] r;
    wreg(adcc_pkg::IDX_CLK, 8'h94);
    wreg(adcc_pkg::IDX_SCR, 8'h42);
    wait_idle();
    `CHK(irq, 1'b1)
    rreg(adcc_pkg::IDX_SCR, r);   `CHK(r, 8'h42)
    rreg(adcc_pkg::IDX_R0_HI, r);
    @(posedge clk);
    `CHK(irq, 1'b0)
    wreg(adcc_pkg::IDX_SCR, 8'h42);
    wait_idle();
    wreg(adcc_pkg::IDX_SCR, 8'h1F);
    `CHK(irq, 1'b0)
  endtask
  task automatic t_chan;
    logic [7:0] r;
    logic [4:0] codes[11] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 29, 30};
    foreach (codes[i]) begin
      wreg(adcc_pkg::IDX_SCR, {3'h0, codes[i]});
      `CHK(mux, codes[i])
      `CHK(pdown, 1'b0)
      wait_idle();
    end
    // entering power-off starts no conversion and sets no flag
    wreg(adcc_pkg::IDX_SCR, 8'h1F);
    repeat (40) @(posedge clk);
    `CHK(busy, 1'b0)
    `CHK(pdown, 1'b1)
    rreg(adcc_pkg::IDX_SCR, r);   `CHK(r, 8'h1F)
  endtask
  task automatic measure(output int per, output int len);
    int n;
    n = 0;
    while (start !== 1'b1 && n < 500) begin
      @(posedge clk);
      n++;
    end
    len = 0;
    for (int k = 0; k < 2; k++) begin
      per = 0;
      do begin
        @(posedge clk);
        per++;
      end while (strobe !== 1'b1 && per < 500);
      len += per;
    end
    while (busy !== 1'b0 && len < 2000) begin
      @(posedge clk);
      len++;
    end
  endtask
  task automatic t_div;
    logic [2:0] codes[6] = '{0, 1, 2, 3, 4, 7};
    int         dv[6] = '{1, 2, 4, 8, 16, 16};
    int         per, len;
    foreach (codes[i]) begin
      wreg(adcc_pkg::IDX_CLK, {codes[i], 5'h14});
      wreg(adcc_pkg::IDX_SCR, 8'h00);
      measure(per, len);
      `CHK(per, dv[i])
      `CHK(len >= 16 * dv[i] && len <= 17 * dv[i] + 2, 1'b1)
      wait_idle();
    end
    wreg(adcc_pkg::IDX_CLK, 8'h04);
    wreg(adcc_pkg::IDX_SCR, 8'h00);
    measure(per, len);
    `CHK(per, 8)
    wait_idle();
  endtask
  task automatic t_cont_lock;
    logic [7:0] r;
    logic [9:0] v;
    int         n;
    wreg(adcc_pkg::IDX_CLK, 8'h94);
    // continuous with scan off
    wreg(adcc_pkg::IDX_SCR, 8'h27);
    n = 0;
    do begin
      rreg(adcc_pkg::IDX_SCR, r);
      n++;
    end while (r[7] !== 1'b1 && n < 400);
    v = smp;
    rreg(adcc_pkg::IDX_R0_HI, r); `CHK(r, {6'h00, v[9:8]})
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (start !== 1'b1 && n < 1000);
    end
    `CHK(busy, 1'b1)
    rreg(adcc_pkg::IDX_R0_LO, r); `CHK(r, v[7:0])
    wreg(adcc_pkg::IDX_SCR, 8'h1F);
    wait_idle();
  endtask
  task automatic t_scan;
    logic [7:0] r;
    int         k;
    k = 0;
    wreg(adcc_pkg::IDX_CLK, 8'h90);
    wreg(adcc_pkg::IDX_SCAN, 8'h06);
    wreg(adcc_pkg::IDX_SCR, 8'h00);
    repeat (1200) begin
      @(posedge clk);
      if (start === 1'b1) begin
        `CHK(mux, 5'(k))
        k++;
      end
    end
    `CHK(k, 3)
    rreg(adcc_pkg::IDX_R2, r);    `CHK(r, smp[9:2])
    wreg(adcc_pkg::IDX_SCAN, 8'h00);
  endtask

  task automatic stop_test;
    $display("mismatches %0d, comparisons %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 10'h000;
    pwdata = 32'h00000000;
    osc_cnt = 3'h0;
    fails = 0;
    tests_run = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_single();
    t_modes();
    t_irq();
    t_chan();
    t_div();
    t_cont_lock();
    t_scan();
    stop_test();
  end
  // whole run needs about 9000 cycles
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    stop_test();
  end
endmodule

// ==== verilog/adcc_format.sv ====
// places the 10-bit result into high and low bytes per justification
module adcc_format (
  adcc_if.fmt ifc
);
  always_comb begin
    ifc.res_hi = 8'h00;
    ifc.res_lo = 8'h00;
    case (ifc.mode)
      adcc_pkg::MODE_TRUNC: begin
        ifc.res_lo = ifc.raw[9:2];
      end
      adcc_pkg::MODE_RIGHT: begin
        ifc.res_hi = {6'h00, ifc.raw[9:8]};
        ifc.res_lo = ifc.raw[7:0];
      end
      adcc_pkg::MODE_LEFT: begin
        ifc.res_hi = ifc.raw[9:2];
        ifc.res_lo = {ifc.raw[1:0], 6'h00};
      end
      default: begin
        ifc.res_hi = {~ifc.raw[9], ifc.raw[8:2]};
        ifc.res_lo = {ifc.raw[1:0], 6'h00};
      end
    endcase
  end
endmodule

// ==== verilog/adcc_prescale.sv ====
// converter clock prescaler: one tick per 1, 2, 4, 8 or 16 source ticks
module adcc_prescale #(
  parameter int CNT_W = 4
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  adcc_if.pre       ifc
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             tick;
  } adcc_pre_type;
  adcc_pre_type s_q, s_d;
  logic [CNT_W-1:0] last;

  if (CNT_W < 4) begin : g_width_check
    $error("prescaler counter too narrow for divide by 16");
  end

  always_comb begin
    // top bit set means divide by 16 whatever the low bits say
    if (ifc.div_code[2]) begin
      last = CNT_W'(15);
    end else begin
      last = CNT_W'((1 << ifc.div_code[1:0]) - 1);
    end
    s_d = s_q;
    s_d.tick = 1'b0;
    if (ifc.src_tick) begin
      if (s_q.cnt >= last) begin
        s_d.cnt  = '0;
        s_d.tick = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ifc.conv_tick = s_q.tick;
endmodule

// ==== verilog/adcc_top.sv ====
// converter control: registers on APB, conversion sequencing, scan, results
module adcc_top (
  input  wire logic        I_REF_CLK,
  input  wire logic        I_RST_N,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [9:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  input  wire logic        I_OSC_CLK,
  input  wire logic [9:0]  I_CORE_DATA,
  output logic      [4:0]  O_MUX_SEL,
  output logic             O_POWER_DOWN,
  output logic             O_CONV_START,
  output logic             O_CONV_STROBE,
  output logic             O_BUSY,
  output logic             O_IRQ
);
  typedef struct packed {
    logic [1:0]              osc_s;
    logic                    osc_prev;
    adcc_pkg::adcc_state_type st;
    logic [3:0]              tick_cnt;
    logic [1:0]              scan_cnt;
    logic                    start;
    logic                    ien;
    logic                    cont;
    logic                    done;
    logic                    irq;
    logic                    lock;
    logic [4:0]              chan;
    logic [2:0]              div;
    logic                    clk_sel;
    logic [1:0]              mode;
    logic                    scan_en;
    logic [1:0]              scan_lim;
    logic [7:0]              r0_hi;
    logic [7:0]              r0_lo;
    logic [7:0]              r1;
    logic [7:0]              r2;
    logic [7:0]              r3;
    logic [31:0]             rdata;
    logic                    slverr;
  } adcc_regs_type;

  adcc_regs_type s_q, s_d;
  adcc_if        lnk ();

  logic       setup;
  logic       wr;
  logic       rd;
  logic [7:0] idx;
  logic       hit;
  logic       wr_scr;
  logic       wr_clk;
  logic       rd_hi0;
  logic       rd_lo0;
  logic       rd_lo_any;
  logic       go;
  logic       again;
  logic [7:0] rv;

  adcc_prescale #(
    .CNT_W   (4)
  ) u_pre (
    .i_clk   (I_REF_CLK),
    .i_rst_n (I_RST_N),
    .ifc     (lnk.pre)
  );

  adcc_format u_fmt (
    .ifc (lnk.fmt)
  );

  // bus clock ticks every cycle; oscillator ticks on its synchronised edge
  assign lnk.src_tick = s_q.clk_sel | (s_q.osc_s[1] & ~s_q.osc_prev);
  assign lnk.div_code = s_q.div;
  assign lnk.raw      = I_CORE_DATA;
  assign lnk.mode     = s_q.mode;

  assign idx       = I_PADDR[9:2];
  assign setup     = I_PSEL & ~I_PENABLE;
  assign wr        = I_PSEL & I_PENABLE & I_PWRITE;
  assign rd        = I_PSEL & I_PENABLE & ~I_PWRITE;
  assign wr_scr    = wr && idx == adcc_pkg::IDX_SCR;
  assign wr_clk    = wr && idx == adcc_pkg::IDX_CLK;
  assign rd_hi0    = rd && idx == adcc_pkg::IDX_R0_HI;
  assign rd_lo0    = rd && idx == adcc_pkg::IDX_R0_LO;
  assign rd_lo_any = rd && idx >= adcc_pkg::IDX_R0_LO && idx <= adcc_pkg::IDX_R3;

  // scan mode ignores the channel field, so power-off only blocks single mode
  assign go = wr_scr &&
              (s_q.scan_en || I_PWDATA[4:0] != adcc_pkg::CHAN_OFF);

  // read value, decoded in the setup phase
  always_comb begin
    hit = 1'b1;
    rv  = 8'h00;
    if (idx == adcc_pkg::IDX_SCR) begin
      // flag is hidden while interrupts are enabled
      rv = {s_q.done & ~s_q.ien, s_q.ien, s_q.cont, s_q.chan};
    end else if (idx == adcc_pkg::IDX_CLK) begin
      rv = {s_q.div, s_q.clk_sel, s_q.mode, 2'h0};
    end else if (idx == adcc_pkg::IDX_R0_HI) begin
      rv = s_q.r0_hi;
    end else if (idx == adcc_pkg::IDX_R0_LO) begin
      rv = s_q.r0_lo;
    end else if (idx == adcc_pkg::IDX_R1) begin
      rv = s_q.r1;
    end else if (idx == adcc_pkg::IDX_R2) begin
      rv = s_q.r2;
    end else if (idx == adcc_pkg::IDX_R3) begin
      rv = s_q.r3;
    end else if (idx == adcc_pkg::IDX_SCAN) begin
      rv = {5'h00, s_q.scan_en, s_q.scan_lim};
    end else begin
      hit = 1'b0;
    end
  end

  // another conversion follows when continuous, or while the scan has channels left
  assign again = s_q.cont ||
                 (s_q.scan_en && s_q.scan_cnt != s_q.scan_lim);

  always_comb begin
    s_d = s_q;
    s_d.osc_s    = {s_q.osc_s[0], I_OSC_CLK};
    s_d.osc_prev = s_q.osc_s[1];
    s_d.start    = 1'b0;
    if (setup) begin
      s_d.rdata  = {24'h000000, rv};
      s_d.slverr = ~hit;
    end

    // clears first, so that a completion in the same cycle wins below
    if (wr_scr) begin
      s_d.ien  = I_PWDATA[adcc_pkg::SCR_IEN_B];
      s_d.cont = I_PWDATA[adcc_pkg::SCR_CONT_B];
      s_d.chan = I_PWDATA[4:0];
      s_d.done = 1'b0;
      s_d.irq  = 1'b0;
      s_d.lock = 1'b0;
    end
    if (wr_clk) begin
      s_d.div     = I_PWDATA[adcc_pkg::CLK_DIV_B +: 3];
      s_d.clk_sel = I_PWDATA[adcc_pkg::CLK_SEL_B];
      s_d.mode    = I_PWDATA[adcc_pkg::CLK_MODE_B +: 2];
      s_d.done    = 1'b0;
      s_d.lock    = 1'b0;
    end
    if (wr && idx == adcc_pkg::IDX_SCAN) begin
      s_d.scan_en  = I_PWDATA[adcc_pkg::SCAN_EN_B];
      s_d.scan_lim = I_PWDATA[1:0];
    end
    if (rd_lo_any) begin
      s_d.done = 1'b0;
    end
    if (rd_lo0) begin
      s_d.lock = 1'b0;
    end
    if (rd_hi0 || rd_lo0) begin
      s_d.irq = 1'b0;
    end
    // truncated mode has no interlock between the bytes
    if (rd_hi0 && s_q.mode != adcc_pkg::MODE_TRUNC) begin
      s_d.lock = 1'b1;
    end

    case (s_q.st)
      adcc_pkg::ST_IDLE: begin
      end
      adcc_pkg::ST_SYNC: begin
        // the wait for the first converter tick is the fractional cycle
        if (lnk.conv_tick) begin
          s_d.st       = adcc_pkg::ST_CONV;
          s_d.tick_cnt = 4'h0;
          s_d.start    = 1'b1;
        end
      end
      adcc_pkg::ST_CONV: begin
        if (lnk.conv_tick) begin
          if (s_q.tick_cnt == adcc_pkg::CONV_TICKS) begin
            s_d.st = adcc_pkg::ST_DONE;
          end else begin
            s_d.tick_cnt = s_q.tick_cnt + 4'h1;
          end
        end
      end
      default: begin
        // result 0 values that arrive while its low byte is frozen are dropped
        if (s_q.scan_en) begin
          case (s_q.scan_cnt)
            2'h0: begin
              if (!s_q.lock) begin
                s_d.r0_lo = lnk.res_lo;
              end
            end
            2'h1: s_d.r1 = lnk.res_lo;
            2'h2: s_d.r2 = lnk.res_lo;
            default: s_d.r3 = lnk.res_lo;
          endcase
        end else if (!s_q.lock) begin
          s_d.r0_hi = lnk.res_hi;
          s_d.r0_lo = lnk.res_lo;
        end
        if (s_q.ien) begin
          s_d.irq = 1'b1;
        end else begin
          s_d.done = 1'b1;
        end
        if (again) begin
          s_d.st = adcc_pkg::ST_SYNC;
          if (s_q.scan_en) begin
            s_d.scan_cnt = s_q.scan_cnt + 2'h1;
          end
        end else begin
          s_d.st = adcc_pkg::ST_IDLE;
        end
      end
    endcase

    // a status/control write aborts any conversion in flight and restarts it unless it powers off
    if (wr_scr) begin
      s_d.scan_cnt = 2'h0;
      if (go) begin
        s_d.st = adcc_pkg::ST_SYNC;
      end else begin
        s_d.st = adcc_pkg::ST_IDLE;
      end
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      s_q          <= '0;
      s_q.st       <= adcc_pkg::ST_IDLE;
      s_q.chan     <= adcc_pkg::CHAN_RST;
      s_q.div      <= adcc_pkg::DIV_RST;
      s_q.clk_sel  <= 1'b0;
      s_q.mode     <= adcc_pkg::MODE_RIGHT;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    if (s_q.scan_en) begin
      O_MUX_SEL = {3'h0, s_q.scan_cnt};
    end else begin
      // reserved codes reach the mux unchanged; the core's answer to them is undefined
      O_MUX_SEL = s_q.chan;
    end
  end

  assign O_POWER_DOWN  = ~s_q.scan_en && s_q.chan == adcc_pkg::CHAN_OFF;
  assign O_CONV_START  = s_q.start;
  assign O_CONV_STROBE = lnk.conv_tick &&
                         (s_q.st == adcc_pkg::ST_CONV || s_q.st == adcc_pkg::ST_SYNC);
  assign O_BUSY        = s_q.st != adcc_pkg::ST_IDLE;
  assign O_IRQ         = s_q.irq;
  assign O_PRDATA      = s_q.rdata;
  assign O_PSLVERR     = s_q.slverr & I_PSEL & I_PENABLE;
  assign O_PREADY      = 1'b1;

  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_RST_N);

  done_set_a: assert property (
    s_q.st == adcc_pkg::ST_DONE && !s_q.ien |=> s_q.done)
    else $error("flag not set after conversion");
  flag_clr_a: assert property (
    wr_clk && s_q.st != adcc_pkg::ST_DONE |=> !s_q.done)
    else $error("flag not cleared by clock control write");
  irq_set_a: assert property (
    s_q.st == adcc_pkg::ST_DONE && s_q.ien |=> O_IRQ)
    else $error("interrupt not raised after conversion");
  irq_clr_a: assert property (
    (rd_hi0 || wr_scr) && s_q.st != adcc_pkg::ST_DONE |=> !O_IRQ)
    else $error("interrupt not dropped");
  // an abort by a status/control write ends the attempt; the oscillator source is too slow
  // for a fixed bound, so only bus-clock conversions are timed
  conv_len_a: assert property (
    disable iff (!I_RST_N || wr_scr)
    $rose(O_CONV_START) && s_q.clk_sel |-> ##[15:300] s_q.st == adcc_pkg::ST_DONE)
    else $error("conversion did not end in time");
  one_shot_a: assert property (
    s_q.st == adcc_pkg::ST_DONE && !s_q.cont && !s_q.scan_en && !wr_scr
    |=> s_q.st == adcc_pkg::ST_IDLE)
    else $error("single conversion repeated");
  power_off_a: assert property (
    wr_scr && I_PWDATA[4:0] == adcc_pkg::CHAN_OFF && !s_q.scan_en
    |=> s_q.st == adcc_pkg::ST_IDLE ##1 !$rose(s_q.done))
    else $error("conversion started while powered off");
  lock_hold_a: assert property (
    s_q.lock && s_q.st == adcc_pkg::ST_DONE |=> $stable(s_q.r0_lo))
    else $error("frozen low byte overwritten");
  scan_stop_a: assert property (
    s_q.st == adcc_pkg::ST_DONE && s_q.scan_en && !s_q.cont && !wr_scr &&
    s_q.scan_cnt == s_q.scan_lim |=> s_q.st == adcc_pkg::ST_IDLE)
    else $error("scan ran past its limit");

  // bus-side clears, flag masking, continuous restart and the result interlock
  flag_hide_a: assert property (
    setup && idx == adcc_pkg::IDX_SCR && s_q.ien |=> !s_q.rdata[adcc_pkg::SCR_DONE_B])
    else $error("flag visible while interrupts enabled");
  ien_no_flag_a: assert property (
    s_q.st == adcc_pkg::ST_DONE && s_q.ien && !s_q.done |=> !s_q.done)
    else $error("flag set while interrupts enabled");
  flag_rd_clr_a: assert property (
    rd_lo_any && s_q.st != adcc_pkg::ST_DONE |=> !s_q.done)
    else $error("flag not cleared by low result read");
  irq_lo_clr_a: assert property (
    rd_lo0 && s_q.st != adcc_pkg::ST_DONE |=> !O_IRQ)
    else $error("interrupt not dropped by low result read");
  cont_next_a: assert property (
    s_q.st == adcc_pkg::ST_DONE && s_q.cont && !wr_scr
    |=> s_q.st == adcc_pkg::ST_SYNC)
    else $error("continuous conversion did not restart");
  lock_set_a: assert property (
    rd_hi0 && s_q.mode != adcc_pkg::MODE_TRUNC |=> s_q.lock)
    else $error("high byte read did not freeze low byte");
  lock_free_a: assert property (
    (wr_scr || wr_clk) |=> !s_q.lock)
    else $error("control write did not release the freeze");
  res_store_a: assert property (
    s_q.st == adcc_pkg::ST_DONE && !s_q.scan_en && !s_q.lock
    |=> s_q.r0_lo == $past(lnk.res_lo) && s_q.r0_hi == $past(lnk.res_hi))
    else $error("result bytes not stored");
  scan_rst_a: assert property (
    wr_scr |=> s_q.scan_cnt == 2'h0)
    else $error("scan counter not restarted");

  cont_cv: cover property (
    s_q.cont && s_q.st == adcc_pkg::ST_DONE ##[1:400] s_q.st == adcc_pkg::ST_DONE);
  scan_cv: cover property (
    s_q.scan_en && s_q.scan_lim == 2'h3 && s_q.scan_cnt == 2'h3 &&
    s_q.st == adcc_pkg::ST_DONE);
  lock_cv: cover property (s_q.lock && s_q.st == adcc_pkg::ST_DONE);
  irq_cv: cover property (s_q.ien && s_q.st == adcc_pkg::ST_DONE ##1 O_IRQ);
  off_cv: cover property (wr_scr && !go);
endmodule
